// ===== design/adc_seq.sv
// sampling sequencer, result fifo and shared parallel host port
// Notes on behaviour
// - sample_start rising edge holds all four track/holds, starts a sequence.
// - further sample_start edges are ignored until the sequence has ended.
// - channels convert in order from first_channel up to the programmed count.
// - each channel takes 2 us on internal timing, else 32 clock pin edges; each result lands in its own of four slots.
// - after the last conversion completion goes low, track/holds track again.
// - bit 2 picks the bank, bits 1:0 give channel count minus one.
// - power_down_bit high powers down; of the other mode bits only bank still matters, for idle tracking.
// - after reset the mode is bank A, single channel.
// - host writes mode with chip-select and write low; latched on release.
// - a written mode stays in force until rewritten or reset.
// - with chip-select high, read and write are ignored and pins float.
// - two low result bits share pins with mode bits 2 and 3.
// - first read falling edge shows channel 1 and raises completion.
// - each read rising edge advances the result pointer.
// - the pointer wraps to channel 1 after four reads, whatever the count.
// - every accepted sample_start resets the pointer to channel 1.
// - clock pin tied high selects internal timing, else its edges time.
// - between sequences buffer sits on channel 1, other bank held.
// - a mode write with power_down_bit clear wakes the device.
// - reset leaves completion high and the sequencer ready.
// - result words are two's complement.

`include "adc_seq_defines.svh"

module adc_result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               count;
  } fifo_state_s;

  fifo_state_s st_reg;
  fifo_state_s st_next;
  logic        push;
  logic        pop;

  // separate count, so full and empty need no spare slot
  assign in_ready  = st_reg.count != CW'(DEPTH);
  assign out_valid = st_reg.count != '0;
  assign out_data  = st_reg.mem[st_reg.rd];

  always_comb begin
    st_next = st_reg;
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH - 1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH - 1)) ? '0 : st_reg.rd + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // adc_result_fifo

module adc_seq
  import adc_seq_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // host strobes, all asynchronous pins
  input  wire logic              sample_start,
  input  wire logic              cs_n,
  input  wire logic              wr_n,
  input  wire logic              rd_n,
  input  wire logic              mode_bit0,
  input  wire logic              mode_bit1,
  // shared result_bus, bits 1:0 double as mode bits 3:2
  input  wire logic [`RES_W-1:0] result_bus_i,
  output logic      [`RES_W-1:0] result_bus_o,
  output logic                   result_bus_oe,
  output logic                   int_n,
  // conversion clock pin
  input  wire logic              ext_clk,
  // analog core
  input  wire logic [`RES_W-1:0] sar_data,
  output logic      [3:0]        track_a,
  output logic      [3:0]        track_b,
  output logic      [`SLOT_W-1:0] buf_ch,
  output logic                   conv_busy,
  output logic                   clk_internal,
  output logic                   power_down
);
  seq_state_s r_reg;
  seq_state_s r_next;
  pins_s      pins;
  logic       wr_act;
  logic       wr_act_prev;
  logic       rd_act;
  logic       rd_act_prev;
  logic       start_edge;
  logic       tick;
  logic       conv_done;
  res_s       push_word;
  logic       push_valid;
  logic       push_ready;
  res_s       pop_word;
  logic       pop_valid;
  logic       pop_ready;

  assign pins = '{start: sample_start, cs_n: cs_n, wr_n: wr_n, rd_n: rd_n,
                  a3: result_bus_i[1], a2: result_bus_i[0],
                  m1: mode_bit1, m0: mode_bit0, ext_clk: ext_clk};

  // read and write strobes only count with chip-select low; sample_start needs none
  assign wr_act      = !r_reg.s2.cs_n && !r_reg.s2.wr_n;
  assign wr_act_prev = !r_reg.prev.cs_n && !r_reg.prev.wr_n;
  assign rd_act      = !r_reg.s2.cs_n && !r_reg.s2.rd_n;
  assign rd_act_prev = !r_reg.prev.cs_n && !r_reg.prev.rd_n;
  assign start_edge  = r_reg.s2.start && !r_reg.prev.start;

  // internal timing when the pin sits high, else its rising edges
  assign tick = r_reg.clk_int || (r_reg.s2.ext_clk && !r_reg.prev.ext_clk);

  // store stays still while the host is reading it
  assign pop_ready = !rd_act;

  always_comb begin
    r_next     = r_reg;
    r_next.s1  = pins;
    r_next.s2  = r_reg.s1;
    r_next.prev = r_reg.s2;
    push_valid = 1'b0;
    // core gives offset binary; flipping the top bit makes two's complement
    push_word  = '{slot: r_reg.ch, data: sar_data ^ `SIGN_FLIP};
    if (r_reg.clk_int) begin
      conv_done = r_reg.tick_cnt == `TICK_W'(`CONV_CYC - 1);
    end else begin
      conv_done = tick
                  && r_reg.tick_cnt == `TICK_W'(`EXT_EDGES_PER_CONV - 1);
    end

    // tie-high detector for the clock pin
    // saturating, so a pin held high for ever never wraps back
    if (!r_reg.s2.ext_clk) begin
      r_next.hi_cnt = '0;
    end else if (r_reg.hi_cnt != `HI_W'(`TIE_HIGH_CYC)) begin
      r_next.hi_cnt = r_reg.hi_cnt + 1'b1;
    end
    r_next.clk_int = r_reg.hi_cnt == `HI_W'(`TIE_HIGH_CYC);

    // mode word follows the pins while write is active
    if (wr_act) begin
      r_next.mode_cap = '{pd: r_reg.s2.a3, bank: r_reg.s2.a2,
                          cnt_m1: {r_reg.s2.m1, r_reg.s2.m0}};
    end
    if (wr_act_prev && !wr_act) begin
      r_next.mode = r_reg.mode_cap;
    end
    r_next.pd = r_next.mode.pd;

    // host read side
    if (rd_act && !rd_act_prev) begin
      r_next.int_n = 1'b1;
    end
    if (rd_act_prev && !rd_act) begin
      r_next.ptr = r_reg.ptr + 1'b1; // two bits wrap after four
    end
    r_next.bus_oe = rd_act;
    // next pointer, so the word is ready when the pins turn around
    r_next.bus_o  = r_reg.store[r_next.ptr];

    // drained results go to their slot
    if (pop_valid && pop_ready) begin
      r_next.store[pop_word.slot] = pop_word.data;
    end

    case (r_reg.seq)
      SEQ_IDLE: begin
        // pulses while busy never reach here
        // ignored pulses leave the pointer where it was
        if (start_edge && !r_reg.mode.pd) begin
          r_next.seq      = SEQ_CONV;
          // mode copied at start; a later write waits for the next sample
          r_next.run      = r_reg.mode;
          r_next.ch       = `SLOT_FIRST;
          r_next.ptr      = `SLOT_FIRST;
          r_next.tick_cnt = '0;
          r_next.track_a  = `TRACK_NONE;
          r_next.track_b  = `TRACK_NONE;
          r_next.busy     = 1'b1;
        end
      end
      SEQ_CONV: begin
        // buffer follows the channel being converted
        r_next.buf_ch = r_reg.ch;
        if (conv_done) begin
          push_valid = 1'b1;
          // a full fifo stalls the channel until room appears
          if (push_ready) begin
            r_next.tick_cnt = '0;
            if (r_reg.ch == r_reg.run.cnt_m1) begin
              r_next.seq = SEQ_DRAIN;
            end else begin
              r_next.ch = r_reg.ch + 1'b1;
            end
          end
        end else if (tick) begin
          r_next.tick_cnt = r_reg.tick_cnt + 1'b1;
        end
      end
      SEQ_DRAIN: begin
        // completion only once every result sits in the store
        if (!pop_valid) begin
          r_next.seq   = SEQ_IDLE;
          r_next.int_n = 1'b0;
          r_next.busy  = 1'b0;
        end
      end
      default: begin
        r_next.seq  = SEQ_IDLE;
        r_next.busy = 1'b0;
      end
    endcase

    // idle: buffer on channel 1, selected bank tracks, other holds
    if (r_next.seq == SEQ_IDLE) begin
      r_next.buf_ch  = `SLOT_FIRST;
      r_next.track_a = r_next.mode.bank ? `TRACK_NONE : `TRACK_ALL;
      r_next.track_b = r_next.mode.bank ? `TRACK_ALL : `TRACK_NONE;
    end
  end

  // syncs reset to idle pin levels, so no false edge follows reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg       <= '0;
      r_reg.mode  <= `MODE_RESET;
      r_reg.int_n <= 1'b1;
      r_reg.s1    <= '1;
      r_reg.s2    <= '1;
      r_reg.prev  <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  // fifo lets capture go on while a read holds the store still
  adc_result_fifo #(
    .WIDTH($bits(res_s)),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .in_valid (push_valid),
    .in_ready (push_ready),
    .in_data  (push_word),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data (pop_word)
  );

  // every output straight from the state register
  assign result_bus_o  = r_reg.bus_o;
  assign result_bus_oe = r_reg.bus_oe;
  assign int_n         = r_reg.int_n;
  assign track_a       = r_reg.track_a;
  assign track_b       = r_reg.track_b;
  assign buf_ch        = r_reg.buf_ch;
  assign conv_busy     = r_reg.busy;
  assign clk_internal  = r_reg.clk_int;
  assign power_down    = r_reg.pd;
endmodule // adc_seq

// ===== design/adc_seq_defines.svh
// timing counts, widths and reset values of the sampling sequencer
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH
`define CLK_PERIOD_NS      25
`define CONV_TIME_NS       2000
`define CONV_CYC           (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define EXT_EDGES_PER_CONV 32
`define TIE_HIGH_CYC       64
`define TICK_W             8
`define HI_W               7
`define RES_W              12
`define SLOT_W             2
`define FIFO_DEPTH         8
`define MODE_RESET         4'h0
`define TRACK_ALL          4'hf
`define TRACK_NONE         4'h0
`define SLOT_FIRST         2'h0
`define SIGN_FLIP          12'h800
`endif

// ===== design/adc_seq_pkg.sv
// types shared by the sequencer and its result fifo
`include "adc_seq_defines.svh"
package adc_seq_pkg;
  typedef struct packed {
    logic pd;
    logic bank;
    logic [1:0] cnt_m1;
  } mode_s;

  typedef struct packed {
    logic start;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic a3;
    logic a2;
    logic m1;
    logic m0;
    logic ext_clk;
  } pins_s;

  typedef struct packed {
    logic [`SLOT_W-1:0] slot;
    logic [`RES_W-1:0]  data;
  } res_s;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_CONV  = 2'h1,
    SEQ_DRAIN = 2'h3
  } seq_e;

  typedef struct packed {
    pins_s                         s1;
    pins_s                         s2;
    pins_s                         prev;
    mode_s                         mode;
    mode_s                         mode_cap;
    mode_s                         run;
    seq_e                          seq;
    logic [`SLOT_W-1:0]            ch;
    logic [`TICK_W-1:0]            tick_cnt;
    logic [`HI_W-1:0]              hi_cnt;
    logic [`SLOT_W-1:0]            ptr;
    logic [3:0][`RES_W-1:0]        store;
    logic [`RES_W-1:0]             bus_o;
    logic                          bus_oe;
    logic                          int_n;
    logic [3:0]                    track_a;
    logic [3:0]                    track_b;
    logic [`SLOT_W-1:0]            buf_ch;
    logic                          busy;
    logic                          clk_int;
    logic                          pd;
  } seq_state_s;
endpackage

// ===== tb/adc_seq_properties.sv
// concurrent checks on the sequencer's host and core pins
module adc_seq_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // host pins
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       result_bus_oe,
  input wire logic       int_n,
  // core side
  input wire logic [3:0] track_a,
  input wire logic [3:0] track_b,
  input wire logic       conv_busy,
  input wire logic       power_down
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] busy_cnt_reg;
  logic       rd_on;
  assign rd_on = !cs_n && !rd_n;
  // pins cross a two-flop sync, so read causes are looked for 2 to 4 back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_cnt_reg <= 9'h000;
    else busy_cnt_reg <= conv_busy ? busy_cnt_reg + 9'h001 : 9'h000;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  drive_needs_read_a: assert property (result_bus_oe |->
    $past(rd_on, 2) || $past(rd_on, 3) || $past(rd_on, 4))
    else $error("pins driven without a read");
  float_cs_high_a: assert property (cs_n [*5] |-> !result_bus_oe)
    else $error("pins driven with chip select high");
  hold_in_run_a: assert property (conv_busy |->
    track_a == 4'h0 && track_b == 4'h0)
    else $error("track/hold tracking during a run");
  track_idle_a: assert property (!conv_busy && !$past(conv_busy)
    && !power_down && !$past(rst) |->
    (track_a == 4'hf) != (track_b == 4'hf))
    else $error("idle bank not tracking");
  done_after_run_a: assert property ($fell(int_n) |->
    $past(conv_busy, 1) || $past(conv_busy, 2))
    else $error("completion without a run");
  raise_on_read_a: assert property ($rose(int_n) |->
    $past(rd_on, 2) || $past(rd_on, 3) || $past(rd_on, 4))
    else $error("completion cleared without a read");
  done_holds_a: assert property (cs_n [*4] ##0 !int_n |=> !int_n)
    else $error("completion dropped without a read");
  run_length_a: assert property ($fell(conv_busy) |->
    busy_cnt_reg >= 9'h050 && busy_cnt_reg <= 9'h154)
    else $error("run length out of range");
  asleep_no_run_a: assert property (power_down && $past(power_down)
    && !conv_busy |=> !conv_busy)
    else $error("run started while powered down");
endmodule // adc_seq_properties

bind adc_seq adc_seq_properties u_adc_seq_properties (.clk, .rst, .cs_n,
  .rd_n, .result_bus_oe, .int_n, .track_a, .track_b, .conv_busy,
  .power_down);

// ===== tb/host_bus_model.sv
// host side of the shared result pins, resolving both drivers
module host_bus_model (
  // clock
  input wire logic        clk,
  // host side
  input wire logic [11:0] host_d,
  input wire logic        host_oe,
  // device side
  input wire logic [11:0] dev_d,
  input wire logic        dev_oe,
  // resolved pins
  output logic     [11:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] last_reg = 12'h000;
  always_ff @(posedge clk) last_reg <= pins;
  // floating pins flip each cycle so a stale word never reads as good
  always_comb begin
    if (dev_oe) pins = dev_d;
    else if (host_oe) pins = host_d;
    else pins = ~last_reg;
  end
endmodule // host_bus_model

// ===== tb/tb.sv
// self-checking bench for the sampling sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, sample_start, cs_n, wr_n, rd_n;
  logic        mode_bit0, mode_bit1, host_oe, result_bus_oe, int_n;
  logic        conv_busy, clk_internal, power_down;
  logic [11:0] host_d, result_bus_i, result_bus_o, sar_data;
  logic [3:0]  track_a, track_b;
  logic [1:0]  buf_ch;
  logic        ext_clk = 1'b1;
  bit          ext_run = 1'b0;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  adc_seq u_adc_seq (.clk, .rst, .sample_start, .cs_n, .wr_n, .rd_n,
    .mode_bit0, .mode_bit1, .result_bus_i, .result_bus_o, .result_bus_oe,
    .int_n, .ext_clk, .sar_data, .track_a, .track_b, .buf_ch,
    .conv_busy, .clk_internal, .power_down);
  host_bus_model u_host_bus_model (.clk, .host_d, .host_oe,
    .dev_d(result_bus_o), .dev_oe(result_bus_oe), .pins(result_bus_i));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // free-running clock pin for the external-timing scenario
  always @(posedge clk) if (ext_run) ext_clk <= ~ext_clk;
  // whole run is about two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_mode(input logic [3:0] m);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    host_oe <= 1'b1;
    host_d <= {10'h000, m[3:2]};
    mode_bit1 <= m[1];
    mode_bit0 <= m[0];
    tick(4);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    tick(2);
    host_oe <= 1'b0;
    tick(6);
  endtask
  task automatic rd(input logic [11:0] exp);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    tick(5);
    #1;
    chk(result_bus_o, exp);
    chk(result_bus_oe, 12'h001);
    chk(int_n, 12'h001);
    @(posedge clk);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    tick(6);
  endtask
  // twice: a second start pulse lands mid-run and must be ignored
  task automatic conv(input int n, input bit twice, input logic [3:0] ta,
                      input int cpc);
    int c;
    c = 0;
    sample_start <= 1'b0;
    tick(3);
    sample_start <= 1'b1;
    while (int_n !== 1'b0 && c < 600) begin
      @(posedge clk);
      c++;
      if (twice && c == 20) sample_start <= 1'b0;
      if (twice && c == 23) sample_start <= 1'b1;
      if (n > 1 && c == cpc + 40) chk(12'(buf_ch), 12'h001);
    end
    chk(12'(c >= n * cpc && c <= n * (cpc + 1) + 12), 12'h001);
    tick(24);
    #1;
    chk(int_n, 12'h000);
    chk(track_a, ta);
    chk(track_b, ta ^ 4'hf);
    chk(12'(buf_ch), 12'h000);
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    sample_start = 1'b1;
    {cs_n, wr_n, rd_n} = 3'h7;
    {mode_bit0, mode_bit1, host_oe} = 3'h0;
    host_d = 12'h000;
    sar_data = 12'h123;
    tick(6);
    rst <= 1'b0;
    tick(80);
    #1;
    chk(int_n, 12'h001);
    chk(power_down, 12'h000);
    chk(clk_internal, 12'h001);
    @(posedge clk);
    conv(1, 1'b0, 4'hf, 80);
    rd(12'h923);
    wr_mode(4'h3);
    sar_data <= 12'h0a5;
    conv(4, 1'b1, 4'hf, 80);
    repeat (4) rd(12'h8a5);
    wr_mode(4'h4);
    sar_data <= 12'h7ff;
    conv(1, 1'b0, 4'h0, 80);
    rd(12'hfff);
    repeat (3) rd(12'h8a5);
    rd(12'hfff);
    sar_data <= 12'h000;
    conv(1, 1'b0, 4'h0, 80);
    rd(12'h800);
    rd_n <= 1'b0;
    tick(8);
    #1;
    chk(result_bus_oe, 12'h000);
    @(posedge clk);
    rd_n <= 1'b1;
    tick(4);
    repeat (3) rd(12'h8a5);
    rd(12'h800);
    wr_mode(4'h8);
    #1;
    chk(power_down, 12'h001);
    @(posedge clk);
    sample_start <= 1'b0;
    tick(3);
    sample_start <= 1'b1;
    tick(200);
    #1;
    chk(conv_busy, 12'h000);
    chk(int_n, 12'h001);
    @(posedge clk);
    wr_mode(4'h1);
    #1;
    chk(power_down, 12'h000);
    @(posedge clk);
    sar_data <= 12'h456;
    conv(2, 1'b0, 4'hf, 80);
    rd(12'hc56);
    conv(2, 1'b0, 4'hf, 80);
    rd(12'hc56);
    ext_run <= 1'b1;
    tick(8);
    #1;
    chk(clk_internal, 12'h000);
    @(posedge clk);
    conv(2, 1'b0, 4'hf, 64);
    rd(12'hc56);
    end_sim();
  end
endmodule // tb
